// ---- nfcp_host.sv ----
// Behaviour
// - ready_busy_n is open drain; system pull-up makes the high level.
// - A full address takes five consecutive address-latch cycles.
// - Cycles carry column 0-7, column 8-12, row 0-7, row 8-15, row 16.
// - Write strobe rise latches command, address or data per latch enables.
// - During read busy strobes stay high; only reset and status accepted.
// - Single-page read is 00h, five address cycles, then 30h.
// - 05h, new column, E0h restarts output at a new column, repeatable.
// - Multi-page read selects at most one block in each district.
// - Both multi-page read addresses share the same in-block page bits.
`include "nfcp_consts.svh"

module nfcp_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Request port
  input wire logic reqValid,
  output logic reqReady,
  input wire nfcp_pkg::nfcp_req_t req,
  input wire logic protectReq,
  // Answer port
  output logic respValid,
  output logic [7:0] respData,
  output logic devBusy,
  // Flash pins
  output nfcp_pkg::nfcp_pins_t flashPins,
  input wire logic [7:0] ioIn,
  input wire logic readyBusyN
);

  // ****************************************
  // Sequence tables
  // ****************************************
  function automatic logic [7:0] addrByte(input logic [`NFCP_COL_W-1:0] col,
                                          input logic [`NFCP_ROW_W-1:0] row,
                                          input logic [3:0] idx);
    logic [7:0] b;
    unique case (idx)
      4'h0: b = col[7:0];
      4'h1: b = {3'h0, col[12:8]};
      4'h2: b = row[7:0];
      4'h3: b = row[15:8];
      default: b = {7'h00, row[16]};
    endcase
    return b;
  endfunction

  function automatic nfcp_pkg::nfcp_item_t seqItem(input nfcp_pkg::nfcp_req_t r,
                                                   input logic [3:0] step);
    nfcp_pkg::nfcp_item_t it;
    it = '{nfcp_pkg::K_END, 8'h00};
    unique case (r.op)
      nfcp_pkg::OP_READ: begin
        if (step == 4'h0) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_READ};
        else if (step <= 4'h5) it = '{nfcp_pkg::K_ADDR, addrByte(r.col, r.row, step - 4'h1)};
        else if (step == 4'h6) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_READ_GO};
      end
      nfcp_pkg::OP_MULTI: begin
        if (step == 4'h0 || step == 4'h6) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_MULTI};
        else if (step <= 4'h5) it = '{nfcp_pkg::K_ADDR, addrByte(r.col, r.row, step - 4'h1)};
        else if (step <= 4'hb) it = '{nfcp_pkg::K_ADDR, addrByte(r.col, r.row2, step - 4'h7)};
        else if (step == 4'hc) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_READ_GO};
      end
      nfcp_pkg::OP_COLCHG: begin
        if (step == 4'h0) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_COL_CHG};
        else if (step <= 4'h2) it = '{nfcp_pkg::K_ADDR, addrByte(r.col, r.row, step - 4'h1)};
        else if (step == 4'h3) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_COL_GO};
      end
      nfcp_pkg::OP_STATUS: if (step == 4'h0) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_STATUS};
      nfcp_pkg::OP_MSTATUS: if (step == 4'h0) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_MSTATUS};
      nfcp_pkg::OP_ECCSTAT: if (step == 4'h0) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_ECC};
      nfcp_pkg::OP_RESET: if (step == 4'h0) it = '{nfcp_pkg::K_CMD, `NFCP_CMD_RESET};
      nfcp_pkg::OP_RDBYTE: it = '{nfcp_pkg::K_END, 8'h00};
    endcase
    return it;
  endfunction

  // ****************************************
  // State
  // ****************************************
  nfcp_pkg::nfcp_regs_t s_reg;
  nfcp_pkg::nfcp_regs_t s_next;
  nfcp_pkg::nfcp_item_t curItem;
  logic busyOk;
  logic multiOk;
  logic colOk;

  assign curItem = seqItem(s_reg.req, s_reg.step);

  // Only reset and status reads may go to a busy device
  assign busyOk = s_reg.rb2 || req.op == nfcp_pkg::OP_STATUS ||
                  req.op == nfcp_pkg::OP_MSTATUS || req.op == nfcp_pkg::OP_RESET;
  assign multiOk = req.row[`NFCP_DIST_BIT] != req.row2[`NFCP_DIST_BIT] &&
                   req.row[`NFCP_PAGE_MSB:0] == req.row2[`NFCP_PAGE_MSB:0] &&
                   !protectReq;
  assign colOk = req.col < `NFCP_PAGE_BYTES;
  assign reqReady = s_reg.st == nfcp_pkg::ST_IDLE && busyOk &&
                    (req.op != nfcp_pkg::OP_ECCSTAT || s_reg.singleRead) &&
                    (req.op != nfcp_pkg::OP_MULTI || multiOk) &&
                    (req.op == nfcp_pkg::OP_RDBYTE || req.op > nfcp_pkg::OP_COLCHG || colOk);

  always_comb begin
    s_next = s_reg;
    s_next.respValid = 1'b0;
    s_next.io1 = ioIn;
    s_next.io2 = s_reg.io1;
    s_next.rb1 = readyBusyN;
    s_next.rb2 = s_reg.rb1;
    s_next.pins.ceN = 1'b0;
    s_next.pins.wpN = !protectReq;
    unique case (s_reg.st)
      nfcp_pkg::ST_IDLE: begin
        if (reqValid && reqReady) begin
          s_next.req = req;
          s_next.step = 4'h0;
          s_next.st = nfcp_pkg::ST_SETUP;
        end
      end
      nfcp_pkg::ST_SETUP: begin
        if (curItem.kind == nfcp_pkg::K_END) begin
          s_next.pins.cle = 1'b0;
          s_next.pins.ale = 1'b0;
          s_next.pins.ioOe = 1'b0;
          unique case (s_reg.req.op)
            nfcp_pkg::OP_READ, nfcp_pkg::OP_MULTI, nfcp_pkg::OP_RESET: begin
              s_next.cnt = 3'(`NFCP_WB_CYC);
              s_next.st = nfcp_pkg::ST_WAITB;
            end
            nfcp_pkg::OP_COLCHG, nfcp_pkg::OP_STATUS, nfcp_pkg::OP_MSTATUS,
            nfcp_pkg::OP_ECCSTAT, nfcp_pkg::OP_RDBYTE: begin
              s_next.cnt = 3'(`NFCP_WHR_CYC);
              s_next.st = nfcp_pkg::ST_WHR;
            end
          endcase
        end else begin
          s_next.pins.weN = 1'b0;
          s_next.pins.cle = curItem.kind == nfcp_pkg::K_CMD;
          s_next.pins.ale = curItem.kind == nfcp_pkg::K_ADDR;
          s_next.pins.ioOe = 1'b1;
          s_next.pins.ioOut = curItem.data;
          s_next.st = nfcp_pkg::ST_HOLD;
        end
      end
      nfcp_pkg::ST_HOLD: begin
        s_next.pins.weN = 1'b1;
        s_next.step = s_reg.step + 4'h1;
        s_next.st = nfcp_pkg::ST_SETUP;
      end
      nfcp_pkg::ST_WAITB: begin
        s_next.cnt = s_reg.cnt - 3'h1;
        if (s_reg.cnt == 3'h1) s_next.st = nfcp_pkg::ST_WAITR;
      end
      nfcp_pkg::ST_WAITR: begin
        if (s_reg.rb2) begin
          s_next.singleRead = s_reg.req.op == nfcp_pkg::OP_READ;
          s_next.st = nfcp_pkg::ST_IDLE;
        end
      end
      nfcp_pkg::ST_WHR: begin
        s_next.cnt = s_reg.cnt - 3'h1;
        if (s_reg.cnt == 3'h1) begin
          if (s_reg.req.op == nfcp_pkg::OP_COLCHG) begin
            s_next.st = nfcp_pkg::ST_IDLE;
          end else begin
            s_next.pins.readStrobeN = 1'b0;
            s_next.cnt = 3'(`NFCP_RE_CYC);
            s_next.st = nfcp_pkg::ST_RDLO;
          end
        end
      end
      nfcp_pkg::ST_RDLO: begin
        s_next.cnt = s_reg.cnt - 3'h1;
        if (s_reg.cnt == 3'h1) begin
          s_next.pins.readStrobeN = 1'b1;
          s_next.respData = s_reg.io2;
          s_next.respValid = 1'b1;
          s_next.st = nfcp_pkg::ST_IDLE;
        end
      end
      default: s_next.st = nfcp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.st <= nfcp_pkg::ST_IDLE;
      s_reg.pins <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  assign flashPins = s_reg.pins;
  assign respValid = s_reg.respValid;
  assign respData = s_reg.respData;
  assign devBusy = !s_reg.rb2;

  // ****************************************
  // Checks
  // ****************************************
  logic [3:0] addrRun;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addrRun <= 4'h0;
    end else if (s_reg.st == nfcp_pkg::ST_SETUP && curItem.kind == nfcp_pkg::K_CMD) begin
      addrRun <= 4'h0;
    end else if (s_reg.st == nfcp_pkg::ST_SETUP && curItem.kind == nfcp_pkg::K_ADDR) begin
      addrRun <= addrRun + 4'h1;
    end
  end

  property p_latch_excl;
    @(posedge ref_clk) disable iff (srst)
      !flashPins.weN |-> !(flashPins.cle && flashPins.ale) && flashPins.readStrobeN;
  endproperty
  a_latch_excl: assert property (p_latch_excl)
    else $error("command and address latch together");

  property p_busy_quiet;
    @(posedge ref_clk) disable iff (srst)
      s_reg.st == nfcp_pkg::ST_WAITR |-> flashPins.weN && flashPins.readStrobeN;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("strobe moved during busy");

  property p_five_addr;
    @(posedge ref_clk) disable iff (srst)
      s_reg.st == nfcp_pkg::ST_SETUP &&
      curItem == nfcp_pkg::nfcp_item_t'{nfcp_pkg::K_CMD, `NFCP_CMD_READ_GO}
      |-> addrRun == 4'(`NFCP_ADDR_CYC) ##1 flashPins.cle && flashPins.ioOut == `NFCP_CMD_READ_GO;
  endproperty
  a_five_addr: assert property (p_five_addr)
    else $error("read start without five address cycles");

  property p_col_two;
    @(posedge ref_clk) disable iff (srst)
      s_reg.st == nfcp_pkg::ST_SETUP &&
      curItem == nfcp_pkg::nfcp_item_t'{nfcp_pkg::K_CMD, `NFCP_CMD_COL_GO}
      |-> addrRun == 4'(`NFCP_COL_CYC);
  endproperty
  a_col_two: assert property (p_col_two)
    else $error("column change without two address cycles");

  property p_col_top;
    @(posedge ref_clk) disable iff (srst)
      s_reg.st == nfcp_pkg::ST_SETUP && curItem.kind == nfcp_pkg::K_ADDR && addrRun == 4'h1
      |=> flashPins.ale && flashPins.ioOut[7:5] == 3'h0;
  endproperty
  a_col_top: assert property (p_col_top)
    else $error("second address cycle top bits set");

  property p_bus_turn;
    @(posedge ref_clk) disable iff (srst)
      !flashPins.readStrobeN |-> !flashPins.ioOe ##0 $past(flashPins.weN, 2);
  endproperty
  a_bus_turn: assert property (p_bus_turn)
    else $error("port driven while reading");

  property p_wait_ready;
    @(posedge ref_clk) disable iff (srst)
      s_reg.st == nfcp_pkg::ST_WAITR && s_reg.rb2 |=> s_reg.st == nfcp_pkg::ST_IDLE;
  endproperty
  a_wait_ready: assert property (p_wait_ready)
    else $error("did not leave busy wait on ready");

  property p_multi_addr;
    @(posedge ref_clk) disable iff (srst)
      reqValid && reqReady && req.op == nfcp_pkg::OP_MULTI
      |-> req.row[`NFCP_DIST_BIT] != req.row2[`NFCP_DIST_BIT] &&
          req.row[`NFCP_PAGE_MSB:0] == req.row2[`NFCP_PAGE_MSB:0];
  endproperty
  a_multi_addr: assert property (p_multi_addr)
    else $error("multi read address pair accepted illegally");

endmodule

// ---- nfcp_consts.svh ----
`ifndef NFCP_CONSTS_SVH
`define NFCP_CONSTS_SVH

// ****************************************
// Command codes
// ****************************************
`define NFCP_CMD_READ 8'h00
`define NFCP_CMD_READ_GO 8'h30
`define NFCP_CMD_COL_CHG 8'h05
`define NFCP_CMD_COL_GO 8'he0
`define NFCP_CMD_MULTI 8'h60
`define NFCP_CMD_STATUS 8'h70
`define NFCP_CMD_MSTATUS 8'h71
`define NFCP_CMD_ECC 8'h7a
`define NFCP_CMD_RESET 8'hff

// ****************************************
// Geometry and address format
// ****************************************
`define NFCP_COL_W 13
`define NFCP_ROW_W 17
`define NFCP_PAGE_BYTES 13'h1080
`define NFCP_PAGE_MSB 5
`define NFCP_DIST_BIT 6
`define NFCP_ADDR_CYC 5
`define NFCP_COL_CYC 2

// ****************************************
// Timing
// ****************************************
`define NFCP_CLK_NS 40
`define NFCP_T_WB_NS 100
`define NFCP_T_WHR_NS 60
`define NFCP_T_REA_NS 20
`define NFCP_SYNC_CYC 2
`define NFCP_WB_CYC ((`NFCP_T_WB_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS)
`define NFCP_WHR_CYC ((`NFCP_T_WHR_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS)
`define NFCP_RE_CYC (((`NFCP_T_REA_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS) + `NFCP_SYNC_CYC)

`endif

// ---- nfcp_pkg.sv ----
`include "nfcp_consts.svh"

package nfcp_pkg;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_MULTI = 3'h1,
    OP_COLCHG = 3'h2,
    OP_STATUS = 3'h3,
    OP_MSTATUS = 3'h4,
    OP_ECCSTAT = 3'h5,
    OP_RESET = 3'h6,
    OP_RDBYTE = 3'h7
  } nfcp_op_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_SETUP = 7'h02,
    ST_HOLD = 7'h04,
    ST_WAITB = 7'h08,
    ST_WAITR = 7'h10,
    ST_WHR = 7'h20,
    ST_RDLO = 7'h40
  } nfcp_state_t;

  typedef enum logic [1:0] {
    K_CMD = 2'h0,
    K_ADDR = 2'h1,
    K_END = 2'h2
  } nfcp_kind_t;

  typedef struct packed {
    nfcp_kind_t kind;
    logic [7:0] data;
  } nfcp_item_t;

  typedef struct packed {
    nfcp_op_t op;
    logic [`NFCP_COL_W-1:0] col;
    logic [`NFCP_ROW_W-1:0] row;
    logic [`NFCP_ROW_W-1:0] row2;
  } nfcp_req_t;

  typedef struct packed {
    logic ceN;
    logic cle;
    logic ale;
    logic weN;
    logic readStrobeN;
    logic wpN;
    logic ioOe;
    logic [7:0] ioOut;
  } nfcp_pins_t;

  typedef struct packed {
    nfcp_state_t st;
    nfcp_req_t req;
    logic [3:0] step;
    logic [2:0] cnt;
    nfcp_pins_t pins;
    logic [7:0] io1;
    logic [7:0] io2;
    logic rb1;
    logic rb2;
    logic singleRead;
    logic respValid;
    logic [7:0] respData;
  } nfcp_regs_t;

endpackage

// ---- nfcp_flash_model.sv ----
module nfcp_flash_model #(
  parameter int BUSY_NS = 4000,
  parameter int RST_NS = 800
) (
  // Strobes and port from the host
  input wire nfcp_pkg::nfcp_pins_t pins,
  // Device side of the port and the busy line
  output logic [7:0] ioDrv,
  output logic busyLow
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Behavioural flash array
  // ****************************************
  logic [7:0] abuf [5];
  logic [7:0] lastOut;
  logic [12:0] col, pendCol;
  logic [16:0] row;
  logic [16:0] rowM [2];
  logic [2:0] acnt;
  logic [1:0] nMulti, outMode;
  logic readArmed, multiDone;
  int badCount;

  task automatic go_busy(input int ns);
    busyLow = 1'h1;
    #(ns);
    busyLow = 1'h0;
  endtask

  initial begin
    ioDrv = 8'hff;
    busyLow = 1'h0;
    lastOut = 8'h00;
    acnt = 3'h0;
    nMulti = 2'h0;
    outMode = 2'h0;
    readArmed = 1'h1;
    multiDone = 1'h0;
    badCount = 0;
  end

  always @(posedge pins.weN) begin
    if (!pins.ceN) begin
      if (!pins.ioOe) badCount++;
      if (busyLow && !(pins.cle && pins.ioOut inside {8'h70, 8'h71, 8'hff})) badCount++;
      if (pins.cle && !pins.ale) begin
        case (pins.ioOut)
          8'h00: begin readArmed = 1'h1; nMulti = 2'h0; acnt = 3'h0; end
          8'h60: begin readArmed = 1'h0; nMulti++; acnt = 3'h0; end
          8'h05, 8'h85: acnt = 3'h0;
          8'he0: begin col = pendCol; outMode = 2'h0; end
          8'h30: begin
            if (readArmed || nMulti == 2'h2) begin
              if (nMulti == 2'h2 && (rowM[0][6] == rowM[1][6] || rowM[0][5:0] != rowM[1][5:0]))
                badCount++;
              col = pendCol;
              multiDone = (nMulti == 2'h2);
              nMulti = 2'h0;
              outMode = 2'h0;
              fork go_busy(BUSY_NS); join_none
            end
          end
          8'h70, 8'h71: outMode = 2'h1;
          8'h7a: outMode = multiDone ? 2'h3 : 2'h2;
          8'hff: begin nMulti = 2'h0; readArmed = 1'h1; fork go_busy(RST_NS); join_none end
          default: ;
        endcase
      end else if (pins.ale && !pins.cle) begin
        abuf[acnt] = pins.ioOut;
        acnt++;
        if (acnt == 3'h2) begin
          pendCol = {abuf[1][4:0], abuf[0]};
          if (abuf[1][7:5] != 3'h0) badCount++;
        end
        if (acnt == 3'h5) begin
          row = {abuf[4][0], abuf[3], abuf[2]};
          if (abuf[4][7:1] != 7'h00) badCount++;
          if (nMulti != 2'h0) rowM[nMulti - 2'h1] = row;
        end
      end
    end
  end

  always @(negedge pins.readStrobeN) begin
    if (!pins.ceN) begin
      if (busyLow && outMode == 2'h0) badCount++;
      case (outMode)
        2'h0: lastOut = col[7:0] ^ row[7:0] ^ {3'h0, col[12:8]};
        2'h1: lastOut = {pins.wpN, !busyLow, !busyLow, 5'h00};
        default: lastOut = {7'h00, outMode == 2'h3};
      endcase
      if (outMode == 2'h0) col++;
      #20 ioDrv = lastOut;
    end
  end

  always @(posedge pins.readStrobeN) ioDrv = ~lastOut;
endmodule

// ---- nand_flash_command_port_tb_top.sv ----
module nand_flash_command_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Bench, device model and checks
  // ****************************************
  logic ref_clk, srst, reqValid, reqReady, protectReq, respValid, devBusy;
  logic readyBusyN, flashLow;
  logic [7:0] respData, ioIn, flashIo, b;
  nfcp_pkg::nfcp_req_t req;
  nfcp_pkg::nfcp_pins_t flashPins;
  int failures, checkCount, cycles;

  assign ioIn = flashPins.ioOe ? flashPins.ioOut : flashIo;
  assign readyBusyN = flashLow ? 1'h0 : 1'h1;

  nfcp_host dut (.ref_clk(ref_clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .protectReq(protectReq), .respValid(respValid), .respData(respData),
    .devBusy(devBusy), .flashPins(flashPins), .ioIn(ioIn), .readyBusyN(readyBusyN));
  nfcp_flash_model flash (.pins(flashPins), .ioDrv(flashIo), .busyLow(flashLow));

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [16:0] exp, input logic [16:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] exp_byte(input logic [12:0] c, input logic [16:0] r);
    return c[7:0] ^ r[7:0] ^ {3'h0, c[12:8]};
  endfunction

  task automatic issue(input nfcp_pkg::nfcp_op_t op, input logic [12:0] c,
                       input logic [16:0] r, input logic [16:0] r2);
    int n;
    n = 0;
    req = '{op, c, r, r2};
    reqValid = 1'h1;
    @(posedge ref_clk);
    while (reqReady !== 1'h1 && n < 2000) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 2000) check_val("request taken", 17'h1, 17'h0);
    #1 reqValid = 1'h0;
    // Let one edge pass so a following request never reuses this time step
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input nfcp_pkg::nfcp_op_t op, output logic [7:0] v);
    int n;
    n = 0;
    issue(op, 13'h0, 17'h0, 17'h0);
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (respValid !== 1'h1 && n < 2000);
    check_val("answer given", 17'h1, 17'(respValid));
    v = respData;
  endtask

  task automatic refuse(input nfcp_pkg::nfcp_op_t op, input logic [12:0] c,
                        input logic [16:0] r, input logic [16:0] r2);
    int hits;
    hits = 0;
    req = '{op, c, r, r2};
    reqValid = 1'h1;
    repeat (30) begin
      @(posedge ref_clk);
      if (reqReady !== 1'h0) hits++;
    end
    #1 reqValid = 1'h0;
    @(posedge ref_clk);
    #1;
    check_val("refused request", 17'h0, 17'(hits));
  endtask

  task automatic t_single();
    int n;
    n = 0;
    issue(nfcp_pkg::OP_READ, 13'h107e, 17'h1abc5, 17'h0);
    while (devBusy !== 1'h1 && n < 80) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check_val("busy after read start", 17'h1, 17'(devBusy));
    rd(nfcp_pkg::OP_RDBYTE, b);
    check_val("column latched", 17'h107e, 17'(flash.pendCol));
    check_val("row latched", 17'h1abc5, flash.row);
    check_val("first byte", 17'(exp_byte(13'h107e, 17'h1abc5)), 17'(b));
    rd(nfcp_pkg::OP_RDBYTE, b);
    check_val("next byte", 17'(exp_byte(13'h107f, 17'h1abc5)), 17'(b));
  endtask

  task automatic t_colchg();
    issue(nfcp_pkg::OP_COLCHG, 13'h0005, 17'h0, 17'h0);
    rd(nfcp_pkg::OP_RDBYTE, b);
    check_val("column change byte", 17'(exp_byte(13'h0005, 17'h1abc5)), 17'(b));
    issue(nfcp_pkg::OP_COLCHG, 13'h1000, 17'h0, 17'h0);
    rd(nfcp_pkg::OP_RDBYTE, b);
    check_val("second change byte", 17'(exp_byte(13'h1000, 17'h1abc5)), 17'(b));
  endtask

  task automatic t_status();
    rd(nfcp_pkg::OP_STATUS, b);
    check_val("status byte", 17'he0, 17'(b));
    protectReq = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 check_val("protect pin", 17'h0, 17'(flashPins.wpN));
    rd(nfcp_pkg::OP_MSTATUS, b);
    check_val("multi status byte", 17'h60, 17'(b));
    refuse(nfcp_pkg::OP_MULTI, 13'h0, 17'h1ffc5, 17'h0a085);
    protectReq = 1'h0;
    rd(nfcp_pkg::OP_STATUS, b);
    check_val("status unprotected", 17'he0, 17'(b));
  endtask

  task automatic t_multi();
    refuse(nfcp_pkg::OP_READ, 13'h1080, 17'h0, 17'h0);
    refuse(nfcp_pkg::OP_MULTI, 13'h0, 17'h1ffc5, 17'h0a0c5);
    refuse(nfcp_pkg::OP_MULTI, 13'h0, 17'h1ffc5, 17'h0a086);
    issue(nfcp_pkg::OP_MULTI, 13'h0, 17'h1ffc5, 17'h0a085);
    rd(nfcp_pkg::OP_STATUS, b);
    check_val("district one first", 17'h1ffc5, flash.rowM[0]);
    check_val("district zero second", 17'h0a085, flash.rowM[1]);
    check_val("multi transfer", 17'h1, 17'(flash.multiDone));
    refuse(nfcp_pkg::OP_ECCSTAT, 13'h0, 17'h0, 17'h0);
    issue(nfcp_pkg::OP_READ, 13'h0010, 17'h00040, 17'h0);
    rd(nfcp_pkg::OP_ECCSTAT, b);
    check_val("ecc status", 17'h0, 17'(b));
    issue(nfcp_pkg::OP_RESET, 13'h0, 17'h0, 17'h0);
    rd(nfcp_pkg::OP_STATUS, b);
    check_val("status after reset", 17'he0, 17'(b));
  endtask

  initial begin
    srst = 1'h1;
    reqValid = 1'h0;
    req = '0;
    protectReq = 1'h0;
    failures = 0;
    checkCount = 0;
    cycles = 0;
    repeat (8) @(posedge ref_clk);
    #1 srst = 1'h0;
    t_single();
    t_colchg();
    t_status();
    t_multi();
    check_val("pin protocol faults", 17'h0, 17'(flash.badCount));
    end_of_test();
  end
endmodule
